// file: hw/srbic_pkg.sv
// constants and types for the system reset, boot and interrupt control block
`default_nettype none
package srbic_pkg;
	// ==========================================================
	// timing
	localparam int CLK_MHZ = 125;
	localparam int POR_DELAY_US = 1000;
	localparam int POR_CYC = POR_DELAY_US * CLK_MHZ;
	localparam int AUTOBAUD_S = 5;
	localparam int AUTOBAUD_CYC = AUTOBAUD_S * CLK_MHZ * 1000000;
	localparam int EXT_RST_CYC = 4;
	localparam int RST_HOLD_CYC = 4;
	// ==========================================================
	// vectors and codes
	localparam logic [15:0] ROM_VEC = 16'h8000;
	localparam logic [15:0] APP_VEC = 16'h0000;
	localparam logic [15:0] IV_RST = 16'h0000;
	localparam logic [15:0] PW_ERASED = 16'hffff;
	localparam logic [7:0] AUTOBAUD_CHAR = 8'h0d;
	// ==========================================================
	// register word indices, byte address is four times these
	localparam logic [5:0] IDX_GIC = 6'h05;
	localparam logic [5:0] IDX_IMR = 6'h06;
	localparam logic [5:0] IDX_SC = 6'h08;
	localparam logic [5:0] IDX_IIR = 6'h0b;
	localparam logic [5:0] IDX_IV = 6'h20;
	localparam logic [5:0] IDX_DBG = 6'h21;
	localparam logic [5:0] IDX_PWR = 6'h22;
	localparam logic [5:0] IDX_SYSF = 6'h23;
	localparam logic [5:0] IDX_SYSE = 6'h24;
	localparam logic [5:0] IDX_EXTF = 6'h25;
	localparam logic [5:0] IDX_EXTE = 6'h26;
	localparam logic [5:0] IDX_PWD = 6'h27;
	localparam logic [5:0] IDX_PWKEY = 6'h28;
	localparam logic [5:0] IDX_BOOT = 6'h29;
	// ==========================================================
	// field positions
	localparam int GIC_IGE = 0;
	localparam int GIC_INS = 1;
	localparam int GIC_CLOCK_GATE_DISABLE = 5;
	localparam int IMR_IMS = 7;
	localparam int SC_PWL = 1;
	localparam int SC_ROD = 2;
	localparam int DBG_SPE = 0;
	localparam int PWR_STOP = 0;
	localparam int PWR_WARM = 1;
	localparam int PWR_CORE_SUPPLY_MONITOR_EN = 2;
	localparam int PWR_ANALOG_SUPPLY_MONITOR_EN = 3;
	localparam int PWR_IO_SUPPLY_MONITOR_EN = 4;
	localparam int PWR_MERASE = 7;
	// ==========================================================
	// reset values
	localparam logic [7:0] GIC_RST = 8'h00;
	localparam logic [7:0] IMR_RST = 8'h00;
	localparam logic [7:0] PWR_RST = 8'h00;
	localparam logic [15:0] PIN_SYNC_RST = 16'h0001;
	// ==========================================================
	// boot sequence
	typedef enum logic [2:0] {
		BT_IDLE = 3'b000,
		BT_JTAG = 3'b001,
		BT_PWCHK = 3'b010,
		BT_UART = 3'b011,
		BT_APP = 3'b100,
		BT_LOADER = 3'b101,
		BT_DEBUG = 3'b110
	} srbic_boot_e;
endpackage
`default_nettype wire

// file: hw/srbic_top.sv
// system reset, boot decision, stop mode, stack and interrupt control
//
// Added by the designer: register access over Avalon-MM.
`default_nettype none
`timescale 1ns/1ns
module srbic_top #(
	parameter int POR_CYCLES = srbic_pkg::POR_CYC,
	parameter int AUTOBAUD_CYCLES = srbic_pkg::AUTOBAUD_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// avalon-mm slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// asynchronous pins
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_n_o,
	input wire logic core_supply_ok_i,
	input wire logic core_low_i,
	input wire logic analog_low_i,
	input wire logic io_low_i,
	input wire logic [7:0] ext_irq_i,
	input wire logic xtal_ready_i,
	input wire logic xtal_fail_i,
	input wire logic jtag_active_i,
	// core side events
	input wire logic wdt_reset_i,
	input wire logic wdt_irq_i,
	input wire logic uart_rx_valid_i,
	input wire logic [7:0] uart_rx_data_i,
	input wire logic [5:0] periph_irq_i,
	input wire logic cpu_call_i,
	input wire logic cpu_ret_i,
	input wire logic cpu_reti_i,
	input wire logic cpu_irq_ack_i,
	input wire logic [15:0] cpu_ret_addr_i,
	input wire logic [1:0] exec_seg_i,
	// data sram port
	input wire logic [10:0] sram_addr_i,
	input wire logic sram_we_i,
	input wire logic [15:0] sram_wdata_i,
	output logic [15:0] sram_rdata_o,
	// status and control out
	output logic sys_reset_o,
	output logic [15:0] fetch_addr_o,
	output logic fetch_go_o,
	output logic loader_run_o,
	output logic debug_run_o,
	output logic rom_util_access_o,
	output logic osc_run_o,
	output logic rc_clk_sel_o,
	output logic cpu_run_o,
	output logic irq_o,
	output logic [15:0] irq_vector_o,
	output logic [15:0] stack_top_o,
	output logic [2:0] data_space_o
);
	localparam int PW = $clog2(POR_CYCLES + 1);
	localparam int AW = $clog2(AUTOBAUD_CYCLES + 1);

	// ==========================================================
	// pin synchronisers
	logic [15:0] sync1, sync2;
	wire [15:0] pin_raw = {jtag_active_i, xtal_fail_i, xtal_ready_i, ext_irq_i,
		io_low_i, analog_low_i, core_low_i, core_supply_ok_i, rst_pin_i};
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync1 <= srbic_pkg::PIN_SYNC_RST;
			sync2 <= srbic_pkg::PIN_SYNC_RST;
		end else if (ce_i) begin
			sync1 <= pin_raw;
			sync2 <= sync1;
		end
	end
	wire pin_s = sync2[0];
	wire core_ok_s = sync2[1];
	wire [2:0] low_s = sync2[4:2];
	wire [7:0] ext_s = sync2[12:5];
	wire xrdy_s = sync2[13];
	wire xfail_s = sync2[14];
	wire jtag_s = sync2[15];

	// ==========================================================
	// bus slave
	logic wait_q;
	logic [7:0] gic, module_irq_mask, pwr, ext_ie, ext_f;
	logic [4:0] sys_f, sys_ie;
	logic [15:0] iv, pwd;
	logic rom_password_lock, debug_privilege_enable, stop_q, warm_wait;
	logic [7:0] irq_source_ident;
	srbic_pkg::srbic_boot_e boot_st, next_boot;
	wire req = avs_read_i | avs_write_i;
	wire wr = avs_write_i & ~wait_q;
	wire [5:0] idx = avs_address_i[7:2];
	wire [31:0] wd = avs_writedata_i;
	wire be0 = avs_byteenable_i[0];
	wire be1 = avs_byteenable_i[1];
	wire s_gic = idx == srbic_pkg::IDX_GIC;
	wire s_imr = idx == srbic_pkg::IDX_IMR;
	wire s_sc = idx == srbic_pkg::IDX_SC;
	wire s_iir = idx == srbic_pkg::IDX_IIR;
	wire s_iv = idx == srbic_pkg::IDX_IV;
	wire s_dbg = idx == srbic_pkg::IDX_DBG;
	wire s_pwr = idx == srbic_pkg::IDX_PWR;
	wire s_sysf = idx == srbic_pkg::IDX_SYSF;
	wire s_syse = idx == srbic_pkg::IDX_SYSE;
	wire s_extf = idx == srbic_pkg::IDX_EXTF;
	wire s_exte = idx == srbic_pkg::IDX_EXTE;
	wire s_pwd = idx == srbic_pkg::IDX_PWD;
	wire s_pwkey = idx == srbic_pkg::IDX_PWKEY;
	wire s_boot = idx == srbic_pkg::IDX_BOOT;
	wire w0 = wr & be0;
	wire w01 = wr & be0 & be1;
	wire [31:0] rd_mux =
		({32{s_gic}} & {24'h0, gic}) |
		({32{s_imr}} & {24'h0, module_irq_mask}) |
		({32{s_sc}} & {29'h0, 1'b0, rom_password_lock, 1'b0}) |
		({32{s_iir}} & {24'h0, irq_source_ident}) |
		({32{s_iv}} & {16'h0, iv}) |
		({32{s_dbg}} & {31'h0, debug_privilege_enable}) |
		({32{s_pwr}} & {24'h0, 1'b0, pwr[6:1], stop_q}) |
		({32{s_sysf}} & {27'h0, sys_f}) |
		({32{s_syse}} & {27'h0, sys_ie}) |
		({32{s_extf}} & {24'h0, ext_f}) |
		({32{s_exte}} & {24'h0, ext_ie}) |
		({32{s_boot}} & {29'h0, boot_st});
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wait_q <= 1'b1;
			avs_readdata_o <= 32'h0;
		end else if (ce_i) begin
			wait_q <= ~(req & wait_q);
			if (avs_read_i & wait_q)
				avs_readdata_o <= rd_mux;
		end
	end
	assign avs_waitrequest_o = wait_q;

	// ==========================================================
	// reset sources
	logic [PW-1:0] por_cnt;
	logic por_busy, rst_act;
	logic [2:0] ext_cnt, hold_cnt;
	wire ext_rst = ext_cnt == 3'(srbic_pkg::EXT_RST_CYC);
	wire int_rst = w0 & s_sc & wd[srbic_pkg::SC_ROD] & debug_privilege_enable;
	wire soft_rst = wdt_reset_i | ext_rst | int_rst;
	wire next_rst = por_busy | soft_rst | (hold_cnt != 3'h0);
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			por_cnt <= '0;
			por_busy <= 1'b1;
			ext_cnt <= 3'h0;
			hold_cnt <= 3'h0;
			rst_act <= 1'b1;
			rst_pin_o <= 1'b0;
			rst_pin_oe_n_o <= 1'b0;
		end else if (ce_i) begin
			if (!core_ok_s)
				por_cnt <= '0;
			else if (por_busy)
				por_cnt <= por_cnt + PW'(1);
			por_busy <= ~core_ok_s | (por_cnt < PW'(POR_CYCLES - 1));
			rst_pin_oe_n_o <= ~por_busy;
			if (pin_s | por_busy)
				ext_cnt <= 3'h0;
			else if (!ext_rst)
				ext_cnt <= ext_cnt + 3'h1;
			if (soft_rst)
				hold_cnt <= 3'(srbic_pkg::RST_HOLD_CYC);
			else if (hold_cnt != 3'h0)
				hold_cnt <= hold_cnt - 3'h1;
			rst_act <= next_rst;
		end
	end
	assign sys_reset_o = rst_act;

	// ==========================================================
	// boot sequence
	logic [AW-1:0] ab_cnt;
	wire pw_set = pwd != srbic_pkg::PW_ERASED;
	wire ab_hit = uart_rx_valid_i & (uart_rx_data_i == srbic_pkg::AUTOBAUD_CHAR);
	wire ab_out = ab_cnt >= AW'(AUTOBAUD_CYCLES - 1);
	always_comb begin
		next_boot = boot_st;
		case (boot_st)
			srbic_pkg::BT_IDLE: next_boot = srbic_pkg::BT_JTAG;
			srbic_pkg::BT_JTAG: next_boot = jtag_s ? srbic_pkg::BT_DEBUG : srbic_pkg::BT_PWCHK;
			srbic_pkg::BT_PWCHK: next_boot = pw_set ? srbic_pkg::BT_APP : srbic_pkg::BT_UART;
			srbic_pkg::BT_UART: begin
				if (ab_hit)
					next_boot = srbic_pkg::BT_LOADER;
				else if (ab_out)
					next_boot = srbic_pkg::BT_APP;
			end
			srbic_pkg::BT_APP: next_boot = srbic_pkg::BT_APP;
			srbic_pkg::BT_LOADER: next_boot = srbic_pkg::BT_LOADER;
			srbic_pkg::BT_DEBUG: next_boot = srbic_pkg::BT_DEBUG;
			default: next_boot = srbic_pkg::BT_IDLE;
		endcase
	end
	wire go_app = (next_boot == srbic_pkg::BT_APP) & (boot_st != srbic_pkg::BT_APP);
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			boot_st <= srbic_pkg::BT_IDLE;
			ab_cnt <= '0;
			fetch_addr_o <= srbic_pkg::ROM_VEC;
			fetch_go_o <= 1'b0;
			loader_run_o <= 1'b0;
			debug_run_o <= 1'b0;
		end else if (ce_i) begin
			if (rst_act) begin
				boot_st <= srbic_pkg::BT_IDLE;
				ab_cnt <= '0;
				fetch_addr_o <= srbic_pkg::ROM_VEC;
				fetch_go_o <= 1'b0;
				loader_run_o <= 1'b0;
				debug_run_o <= 1'b0;
			end else begin
				boot_st <= next_boot;
				if (boot_st == srbic_pkg::BT_UART)
					ab_cnt <= ab_cnt + AW'(1);
				if (go_app)
					fetch_addr_o <= srbic_pkg::APP_VEC;
				fetch_go_o <= go_app;
				loader_run_o <= next_boot == srbic_pkg::BT_LOADER;
				debug_run_o <= next_boot == srbic_pkg::BT_DEBUG;
			end
		end
	end

	// ==========================================================
	// control registers, lock and password
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rom_password_lock <= 1'b1;
			rom_util_access_o <= 1'b0;
			pwd <= srbic_pkg::PW_ERASED;
		end else if (ce_i) begin
			if (por_busy)
				rom_password_lock <= 1'b1;
			else if (w01 & s_pwkey & (wd[15:0] == pwd))
				rom_password_lock <= 1'b0;
			else if (w0 & s_sc & wd[srbic_pkg::SC_PWL])
				rom_password_lock <= 1'b1;
			if (w0 & s_pwr & wd[srbic_pkg::PWR_MERASE])
				pwd <= srbic_pkg::PW_ERASED;
			else if (w01 & s_pwd & ~rom_password_lock)
				pwd <= wd[15:0];
			rom_util_access_o <= ~rom_password_lock;
		end
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			gic <= srbic_pkg::GIC_RST;
			module_irq_mask <= srbic_pkg::IMR_RST;
			pwr <= srbic_pkg::PWR_RST;
			iv <= srbic_pkg::IV_RST;
			debug_privilege_enable <= 1'b0;
			sys_ie <= 5'h0;
			ext_ie <= 8'h0;
		end else if (ce_i) begin
			if (rst_act) begin
				gic <= srbic_pkg::GIC_RST;
				module_irq_mask <= srbic_pkg::IMR_RST;
				pwr <= srbic_pkg::PWR_RST;
				iv <= srbic_pkg::IV_RST;
				debug_privilege_enable <= 1'b0;
				sys_ie <= 5'h0;
				ext_ie <= 8'h0;
			end else begin
				if (w0 & s_gic)
					gic <= {2'b0, wd[5], 3'b0, gic[1] | cpu_irq_ack_i, wd[0]};
				else if (cpu_irq_ack_i)
					gic[srbic_pkg::GIC_INS] <= 1'b1;
				else if (cpu_reti_i)
					gic[srbic_pkg::GIC_INS] <= 1'b0;
				if (w0 & s_imr)
					module_irq_mask <= wd[7:0];
				if (w0 & s_pwr)
					pwr <= {1'b0, wd[6:0]};
				if (w01 & s_iv)
					iv <= wd[15:0];
				if (w0 & s_dbg)
					debug_privilege_enable <= wd[srbic_pkg::DBG_SPE];
				if (w0 & s_syse)
					sys_ie <= wd[4:0];
				if (w0 & s_exte)
					ext_ie <= wd[7:0];
			end
		end
	end

	// ==========================================================
	// interrupt flags and request
	logic [7:0] ext_d;
	logic [2:0] low_d;
	logic xfail_d;
	wire [2:0] bo_en = {pwr[srbic_pkg::PWR_IO_SUPPLY_MONITOR_EN], pwr[srbic_pkg::PWR_ANALOG_SUPPLY_MONITOR_EN], pwr[srbic_pkg::PWR_CORE_SUPPLY_MONITOR_EN]};
	wire [2:0] bo_ev = low_s & ~low_d & bo_en;
	wire [7:0] ext_ev = ext_s & ~ext_d;
	wire [4:0] sys_set = {xfail_s & ~xfail_d, bo_ev[2], bo_ev[1], bo_ev[0], wdt_irq_i};
	wire [4:0] sys_clr = (w0 & s_sysf) ? wd[4:0] : 5'h0;
	wire [7:0] ext_clr = (w0 & s_extf) ? wd[7:0] : 8'h0;
	wire sys_pend = |(sys_f & sys_ie) & module_irq_mask[srbic_pkg::IMR_IMS];
	wire [6:0] mod_pend = {periph_irq_i, |(ext_f & ext_ie)} & module_irq_mask[6:0];
	wire any_pend = sys_pend | (|mod_pend);
	wire next_irq = gic[srbic_pkg::GIC_IGE] & ~gic[srbic_pkg::GIC_INS] & any_pend & ~rst_act;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ext_d <= 8'h0;
			low_d <= 3'h0;
			xfail_d <= 1'b0;
			sys_f <= 5'h0;
			ext_f <= 8'h0;
			irq_source_ident <= 8'h0;
			irq_o <= 1'b0;
			irq_vector_o <= srbic_pkg::IV_RST;
		end else if (ce_i) begin
			ext_d <= ext_s;
			low_d <= low_s;
			xfail_d <= xfail_s;
			if (rst_act) begin
				sys_f <= 5'h0;
				ext_f <= 8'h0;
			end else begin
				sys_f <= (sys_f & ~sys_clr) | sys_set;
				ext_f <= (ext_f & ~ext_clr) | ext_ev;
			end
			irq_source_ident <= {sys_pend, mod_pend};
			irq_o <= next_irq;
			irq_vector_o <= rst_act ? srbic_pkg::IV_RST : iv;
		end
	end

	// ==========================================================
	// stop mode and clocks
	wire wake = |(ext_ev & ext_ie);
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			stop_q <= 1'b0;
			warm_wait <= 1'b0;
			rc_clk_sel_o <= 1'b1;
			osc_run_o <= 1'b1;
			cpu_run_o <= 1'b0;
		end else if (ce_i) begin
			if (rst_act) begin
				stop_q <= 1'b0;
				warm_wait <= 1'b0;
				rc_clk_sel_o <= 1'b1;
			end else if (stop_q) begin
				if (wake) begin
					stop_q <= 1'b0;
					warm_wait <= pwr[srbic_pkg::PWR_WARM];
					rc_clk_sel_o <= 1'b1;
				end
			end else if (w0 & s_pwr & wd[srbic_pkg::PWR_STOP]) begin
				stop_q <= 1'b1;
			end else begin
				if (xrdy_s) begin
					warm_wait <= 1'b0;
					rc_clk_sel_o <= xfail_s;
				end
			end
			osc_run_o <= ~stop_q | gic[srbic_pkg::GIC_CLOCK_GATE_DISABLE];
			cpu_run_o <= ~next_rst & ~stop_q & ~warm_wait;
		end
	end

	// ==========================================================
	// hardware stack and memory map
	logic [15:0] stk [16];
	logic [3:0] sp;
	wire push = cpu_call_i | cpu_irq_ack_i;
	wire pop = cpu_ret_i | cpu_reti_i;
	wire [3:0] sp_m2 = sp - 4'h2;
	always_ff @(posedge clk_i) begin
		if (ce_i & push)
			stk[sp] <= cpu_ret_addr_i;
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sp <= 4'h0;
			stack_top_o <= 16'h0;
			data_space_o <= 3'h6;
		end else if (ce_i) begin
			if (rst_act) begin
				sp <= 4'h0;
				stack_top_o <= 16'h0;
			end else if (push) begin
				sp <= sp + 4'h1;
				stack_top_o <= cpu_ret_addr_i;
			end else if (pop) begin
				sp <= sp - 4'h1;
				stack_top_o <= stk[sp_m2];
			end
			case (exec_seg_i)
				2'h0: data_space_o <= 3'h6;
				2'h1: data_space_o <= 3'h5;
				default: data_space_o <= 3'h3;
			endcase
		end
	end

	// ==========================================================
	// data sram, never cleared by any reset
	logic [15:0] sram [2048];
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (sram_we_i)
				sram[sram_addr_i] <= sram_wdata_i;
			sram_rdata_o <= sram[sram_addr_i];
		end
	end
endmodule // srbic_top
`default_nettype wire

// file: test/srbic_checker.sv
// port assertions for the reset, boot and interrupt control block
`timescale 1ns/1ns
`default_nettype none
module srbic_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// inputs watched
	input wire logic ce_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [1:0] exec_seg_i,
	// outputs watched
	input wire logic avs_waitrequest_o,
	input wire logic rst_pin_o,
	input wire logic rst_pin_oe_n_o,
	input wire logic sys_reset_o,
	input wire logic [15:0] fetch_addr_o,
	input wire logic fetch_go_o,
	input wire logic rom_util_access_o,
	input wire logic osc_run_o,
	input wire logic cpu_run_o,
	input wire logic irq_o,
	input wire logic [15:0] irq_vector_o,
	input wire logic [2:0] data_space_o
);
	// ======================================
	// helpers
	logic [2:0] exp_space;
	assign exp_space = (exec_seg_i == 2'h0) ? 3'h6 : (exec_seg_i == 2'h1) ? 3'h5 : 3'h3;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	sequence s_held_reset;
		sys_reset_o && $past(sys_reset_o);
	endsequence
	sequence s_bus_request;
		ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	// ======================================
	// assertions
	a_reset_fetch_rom: assert property (s_held_reset |-> fetch_addr_o == 16'h8000)
		else $error("fetch address not 8000 in reset");
	a_reset_halts_core: assert property (s_held_reset |-> !cpu_run_o && !irq_o)
		else $error("core or request active in reset");
	a_vector_cleared: assert property (s_held_reset |-> irq_vector_o == 16'h0000)
		else $error("vector not cleared in reset");
	a_pin_por_low: assert property (!rst_pin_oe_n_o |-> sys_reset_o && !rst_pin_o)
		else $error("pin driven outside power-on reset");
	a_lock_after_por: assert property ($fell(reset_i) |-> !rom_util_access_o)
		else $error("utilities free after power-on");
	a_app_start: assert property (fetch_go_o |=> !fetch_go_o && fetch_addr_o == 16'h0000)
		else $error("application start not at 0000");
	a_space_follows: assert property (!sys_reset_o && ce_i |=> sys_reset_o || data_space_o == $past(exp_space))
		else $error("data space does not follow execution segment");
	a_two_data_segs: assert property ($countones(data_space_o) == 2)
		else $error("data space count wrong");
	a_stop_holds_core: assert property (!osc_run_o && !$past(osc_run_o) |-> !cpu_run_o)
		else $error("core runs in stop");
	a_bus_answers: assert property (s_bus_request |=> !avs_waitrequest_o)
		else $error("bus answer late");
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
endmodule // srbic_checker
bind srbic_top srbic_checker checker_i (.clk_i, .reset_i, .ce_i, .avs_read_i, .avs_write_i, .exec_seg_i,
	.avs_waitrequest_o, .rst_pin_o, .rst_pin_oe_n_o, .sys_reset_o, .fetch_addr_o, .fetch_go_o,
	.rom_util_access_o, .osc_run_o, .cpu_run_o, .irq_o, .irq_vector_o, .data_space_o);
`default_nettype wire

// file: test/srbic_host.sv
// model of the external reset source and boot host
`timescale 1ns/1ns
`default_nettype none
module srbic_host (
	// clock
	input wire logic clk_i,
	// toward the device
	output logic rst_low_o,
	output logic jtag_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o
);
	initial begin
		{rst_low_o, jtag_o, rx_valid_o} = 3'h0;
		rx_data_o = 8'h00;
	end
	// pin held low no shorter than four clocks
	task pin_reset(input int cyc);
		@(posedge clk_i);
		rst_low_o <= 1'b1;
		repeat ((cyc < 4) ? 4 : cyc) @(posedge clk_i);
		rst_low_o <= 1'b0;
	endtask
	// one received byte, data scrambled once released
	task send_byte(input logic [7:0] b);
		@(posedge clk_i);
		rx_valid_o <= 1'b1;
		rx_data_o <= b;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_data_o <= ~b;
	endtask
	task set_jtag(input logic v);
		@(posedge clk_i);
		jtag_o <= v;
	endtask
endmodule // srbic_host
`default_nettype wire

// file: test/srbic_top_test.sv
// self-checking bench for the reset, boot and interrupt control block
`timescale 1ns/1ns
`default_nettype none
module srbic_top_test;
	// ======================================
	// signals
	logic clk_i, reset_i, ce_i, avs_read_i, avs_write_i, rst_pin_i, core_supply_ok_i, xtal_ready_i, xtal_fail_i;
	logic [7:0] avs_address_i, ext_irq_i, uart_rx_data_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [3:0] avs_byteenable_i, ctl;
	logic avs_waitrequest_o, rst_pin_o, rst_pin_oe_n_o, jtag_active_i, wdt_reset_i, wdt_irq_i, uart_rx_valid_i;
	logic core_low_i, analog_low_i, io_low_i, host_low, cpu_call_i, cpu_ret_i, cpu_reti_i, cpu_irq_ack_i;
	logic [5:0] periph_irq_i;
	logic [15:0] cpu_ret_addr_i, sram_wdata_i, sram_rdata_o, fetch_addr_o, irq_vector_o, stack_top_o, v, w;
	logic [1:0] exec_seg_i;
	logic [10:0] sram_addr_i;
	logic sram_we_i, sys_reset_o, fetch_go_o, loader_run_o, debug_run_o, rom_util_access_o, osc_run_o;
	logic rc_clk_sel_o, cpu_run_o, irq_o;
	logic [2:0] data_space_o, lows;
	int seed, miscompares, tests_run, cycles, n, i;
	assign rst_pin_i = !(host_low || (!rst_pin_oe_n_o && !rst_pin_o));
	assign {cpu_call_i, cpu_ret_i, cpu_irq_ack_i, cpu_reti_i} = ctl;
	assign {io_low_i, analog_low_i, core_low_i} = lows;
	srbic_top #(.POR_CYCLES(20), .AUTOBAUD_CYCLES(50)) dut (.clk_i, .reset_i, .ce_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .rst_pin_i,
		.rst_pin_o, .rst_pin_oe_n_o, .core_supply_ok_i, .core_low_i, .analog_low_i, .io_low_i, .ext_irq_i,
		.xtal_ready_i, .xtal_fail_i, .jtag_active_i, .wdt_reset_i, .wdt_irq_i, .uart_rx_valid_i, .uart_rx_data_i,
		.periph_irq_i, .cpu_call_i, .cpu_ret_i, .cpu_reti_i, .cpu_irq_ack_i, .cpu_ret_addr_i, .exec_seg_i,
		.sram_addr_i, .sram_we_i, .sram_wdata_i, .sram_rdata_o, .sys_reset_o, .fetch_addr_o, .fetch_go_o,
		.loader_run_o, .debug_run_o, .rom_util_access_o, .osc_run_o, .rc_clk_sel_o, .cpu_run_o, .irq_o,
		.irq_vector_o, .stack_top_o, .data_space_o);
	srbic_host host (.clk_i, .rst_low_o(host_low), .jtag_o(jtag_active_i), .rx_valid_o(uart_rx_valid_i),
		.rx_data_o(uart_rx_data_i));
	initial clk_i = 1'b0;
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			complete_run();
		end
	end
	// ======================================
	// tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		exec_seg_i <= 2'($random(seed));
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		bus(1'b0, a, 32'h0);
		chk(rd, exp, nm);
	endtask
	task boot_to(input logic [2:0] st);
		while (sys_reset_o !== 1'b0) @(posedge clk_i);
		do bus(1'b0, 8'ha4, 32'h0); while (rd[2:0] !== st);
	endtask
	task pulse(input logic [3:0] c, input logic [15:0] d);
		@(posedge clk_i);
		ctl <= c;
		cpu_ret_addr_i <= d;
		@(posedge clk_i);
		ctl <= 4'h0;
		repeat (2) @(posedge clk_i);
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ======================================
	// sequence
	initial begin
		{seed, miscompares, tests_run, cycles} = {32'd47, 96'd0};
		{reset_i, ce_i, core_supply_ok_i, xtal_ready_i, avs_byteenable_i} = 8'hff;
		{avs_read_i, avs_write_i, xtal_fail_i, wdt_reset_i, wdt_irq_i, sram_we_i, ctl, lows} = 13'h0;
		{avs_address_i, avs_writedata_i, ext_irq_i, periph_irq_i, exec_seg_i} = 56'h0;
		{cpu_ret_addr_i, sram_addr_i, sram_wdata_i} = 43'h0;
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		chk({sys_reset_o, rst_pin_oe_n_o}, 2'b10, "power-on pin");
		chk(rc_clk_sel_o, 1'b1, "rc after reset");
		boot_to(3'h3);
		chk({fetch_addr_o, rom_util_access_o}, {16'h8000, 1'b0}, "rom start and lock");
		i = cycles;
		rdchk(8'h14, 32'h0, "global control");
		rdchk(8'h18, 32'h0, "module mask");
		rdchk(8'h80, 32'h0, "vector");
		rdchk(8'hfc, 32'h0, "unmapped");
		while (fetch_go_o !== 1'b1) @(posedge clk_i);
		n = cycles - i;
		chk({n > 40, n < 60, loader_run_o}, 3'b110, "autobaud wait");
		$display("finished boot timeout");
		w = 16'($random(seed));
		@(posedge clk_i);
		{sram_addr_i, sram_wdata_i, sram_we_i} <= {11'($random(seed)), w, 1'b1};
		@(posedge clk_i);
		sram_we_i <= 1'b0;
		host.pin_reset(6);
		repeat (2) @(posedge clk_i);
		chk({sys_reset_o, cpu_run_o}, 2'b10, "pin reset");
		boot_to(3'h3);
		host.send_byte(8'h0d);
		repeat (3) @(posedge clk_i);
		chk({loader_run_o, sram_rdata_o}, {1'b1, w}, "loader and sram");
		$display("finished pin reset");
		bus(1'b1, 8'ha0, 32'hffff);
		repeat (2) @(posedge clk_i);
		chk(rom_util_access_o, 1'b1, "unlock");
		bus(1'b1, 8'h9c, 32'($random(seed)) & 32'h7fff);
		bus(1'b1, 8'h84, 32'h1);
		bus(1'b1, 8'h20, 32'h4);
		repeat (3) @(posedge clk_i);
		chk(sys_reset_o, 1'b1, "internal reset");
		while (sys_reset_o !== 1'b0) @(posedge clk_i);
		for (n = 0; fetch_go_o !== 1'b1; n++) @(posedge clk_i);
		chk({n < 20, rom_util_access_o}, 2'b11, "password boot");
		bus(1'b1, 8'h20, 32'h4);
		repeat (3) @(posedge clk_i);
		chk(sys_reset_o, 1'b0, "no privilege");
		bus(1'b1, 8'h88, 32'h80);
		bus(1'b1, 8'h20, 32'h2);
		repeat (2) @(posedge clk_i);
		chk(rom_util_access_o, 1'b0, "relock");
		bus(1'b1, 8'ha0, 32'hffff);
		repeat (2) @(posedge clk_i);
		chk(rom_util_access_o, 1'b1, "erased password");
		$display("finished password");
		v = 16'($random(seed));
		bus(1'b1, 8'h80, {16'h0, v});
		rdchk(8'h80, {16'h0, v}, "vector rw");
		@(posedge clk_i);
		ext_irq_i <= 8'h08;
		repeat (4) @(posedge clk_i);
		rdchk(8'h94, 32'h08, "disabled flag");
		chk(irq_o, 1'b0, "masked request");
		bus(1'b1, 8'h98, 32'h08);
		bus(1'b1, 8'h18, 32'h03);
		bus(1'b1, 8'h14, 32'h01);
		repeat (3) @(posedge clk_i);
		chk({irq_o, irq_vector_o}, {1'b1, v}, "request and vector");
		rdchk(8'h2c, 32'h01, "ident ext");
		periph_irq_i <= 6'h01;
		rdchk(8'h2c, 32'h03, "ident module");
		periph_irq_i <= 6'h00;
		bus(1'b1, 8'h94, 32'h08);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 1'b0, "flag clear");
		for (i = 0; i < 3; i++) begin
			lows <= 3'h1 << i;
			repeat (4) @(posedge clk_i);
			rdchk(8'h8c, 32'h0, "monitor off");
			lows <= 3'h0;
			bus(1'b1, 8'h88, 32'h4 << i);
			lows <= 3'h1 << i;
			repeat (4) @(posedge clk_i);
			rdchk(8'h8c, 32'h2 << i, "monitor on");
			bus(1'b1, 8'h88, 32'h0);
			lows <= 3'h0;
			bus(1'b1, 8'h8c, 32'h1f);
		end
		xtal_fail_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rdchk(8'h8c, 32'h10, "crystal fail flag");
		$display("finished interrupts");
		w = 16'($random(seed));
		pulse(4'b1000, v);
		pulse(4'b0010, w);
		chk(stack_top_o, w, "push");
		pulse(4'b0001, 16'h0);
		chk(stack_top_o, v, "pop");
		pulse(4'b0100, 16'h0);
		bus(1'b1, 8'h98, 32'h01);
		bus(1'b1, 8'h88, 32'h01);
		repeat (3) @(posedge clk_i);
		chk({osc_run_o, cpu_run_o}, 2'b00, "stop");
		ext_irq_i <= 8'h09;
		repeat (6) @(posedge clk_i);
		chk(osc_run_o, 1'b1, "wake");
		chk(cpu_run_o, 1'b1, "run on wake");
		host.set_jtag(1'b1);
		wdt_reset_i <= 1'b1;
		@(posedge clk_i);
		wdt_reset_i <= 1'b0;
		@(posedge clk_i);
		chk(sys_reset_o, 1'b1, "watchdog reset");
		boot_to(3'h6);
		chk({debug_run_o, irq_vector_o}, {1'b1, 16'h0}, "debug boot");
		$display("finished stack, stop and watchdog");
		complete_run();
	end
endmodule // srbic_top_test
`default_nettype wire
